// ===== ext_bus_pkg.sv
// shared constants and carrier types for the external bus pin block
// assumes one 40 MHz core clock; no software-visible registers
package ext_bus_pkg;
  localparam int INT_ADDR_W     = 24;               // internal address width
  localparam int EXT_ADDR_W     = 21;               // address bits reaching pins
  localparam int LOW_ADDR_W     = 16;               // dedicated low address outputs
  localparam int EXTA_W         = 5;                // extended address outputs
  localparam int DATA_W         = 16;               // shared line width
  localparam logic [23:0] RESET_INT_FETCH = 24'hFF_2080; // fetch from internal memory
  localparam logic [23:0] RESET_EXT_FETCH = 24'h1F_2080; // fetch from external memory
  localparam logic [23:0] EXT_SPACE_TOP   = 24'h1F_FFFF; // last external address
  localparam logic [1:0]  PHASE_CYCLES    = 2'h2;        // core clocks per bus-cycle half

  // per-access chip-select configuration
  typedef struct packed {
    logic bus16;   // 16-bit width when set
    logic demux;   // demultiplexed when set
  } bus_cfg_t;

  // access request from the core
  typedef struct packed {
    logic [23:0] addr;   // full internal address
    logic        write;  // write when set
    logic [15:0] wdata;  // write data
    bus_cfg_t    cfg;    // chip-select configuration
  } bus_req_t;
endpackage : ext_bus_pkg

// ===== ext_bus_phase.sv
// half-cycle sequencer for one external bus cycle
// assumes start is a one-cycle pulse while idle
`timescale 1ns/100ps
module ext_bus_phase (
  input  wire logic mclk_i,    // core clock
  input  wire logic srst_i,    // synchronous reset
  input  wire logic start_i,   // begin a bus cycle
  output logic      busy_o,    // cycle in progress
  output logic      second_o,  // second half active
  output logic      last_o,    // final clock of the cycle
  output logic      flip_o     // final clock of the first half
);
  typedef enum logic [1:0] {PH_IDLE, PH_FIRST, PH_SECOND} phase_t;
  phase_t     state;   // current half
  logic [1:0] cnt;     // clocks within half
  wire        half_end = (cnt == ext_bus_pkg::PHASE_CYCLES - 2'h1);

  // advance one half every PHASE_CYCLES clocks
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= PH_IDLE;
      cnt   <= 2'h0;
    end else begin
      unique case (state)
        PH_IDLE: if (start_i) begin
          state <= PH_FIRST;
          cnt   <= 2'h0;
        end
        PH_FIRST: begin
          cnt <= half_end ? 2'h0 : cnt + 2'h1;
          if (half_end) state <= PH_SECOND;
        end
        PH_SECOND: begin
          cnt <= half_end ? 2'h0 : cnt + 2'h1;
          if (half_end) state <= PH_IDLE;
        end
      endcase
    end
  end

  assign busy_o   = (state != PH_IDLE);
  assign second_o = (state == PH_SECOND);
  assign last_o   = (state == PH_SECOND) && half_end;
  // lets the pin stage pick the data half one clock ahead of the turn
  assign flip_o   = (state == PH_FIRST) && half_end;
endmodule : ext_bus_phase

// ===== ext_bus_pins.sv
// external address/data bus pin driver: address outputs, shared lines, strobe
// assumes core issues one request at a time and waits for done
`timescale 1ns/100ps
module ext_bus_pins (
  input  wire logic                  mclk_i,             // core clock
  input  wire logic                  srst_i,             // synchronous reset
  input  wire logic                  exec_ext_i,         // run from external memory
  input  wire logic                  req_valid_i,        // access request
  input  wire ext_bus_pkg::bus_req_t req_i,              // request payload
  input  wire logic [15:0]           int_bus_hi_i,       // internal bus, high byte in [15:8]
  input  wire logic [15:0]           ad_in_i,            // shared line input
  output logic                       req_ready_o,        // request may be taken
  output logic                       ext_access_o,       // last access went out
  output logic                       done_o,             // access done pulse
  output logic [15:0]                rdata_o,            // read data
  output logic [23:0]                reset_fetch_o,      // reset fetch address
  output logic [15:0]                low_addr_out_o,     // dedicated low address
  output logic [4:0]                 ext_addr_out_o,     // extended address
  output logic [15:0]                shared_addr_data_o, // shared line output
  output logic [15:0]                shared_oe_o,        // shared line drive enable
  output logic                       address_valid_n_o   // address valid strobe
);
  // input sampling, three stages; second and third must agree
  logic [15:0] ad_s1, ad_s2, ad_s3, ad_q;

  ext_bus_pkg::bus_req_t cur;   // captured access
  logic        start;           // launch a bus cycle
  logic        busy, second, last;
  logic        phase_flip;      // final clock of the first half
  logic [2:0]  drain;           // clocks since the strobe rose, for the line sampler
  logic [2:0]  strap_sync;      // strap pin sampler, three stages
  logic        strap_q;         // strap level once stages two and three agree
  logic        reset_seen;      // strap captured after release

  // decode: external when inside the 2 Mbyte window
  function automatic logic is_external(input logic [23:0] a);
    is_external = (a <= ext_bus_pkg::EXT_SPACE_TOP);
  endfunction : is_external

  wire accept   = req_valid_i && req_ready_o;
  wire go_ext   = accept && is_external(req_i.addr);
  wire int_done = accept && !is_external(req_i.addr);
  wire [20:0] pin_addr = cur.addr[ext_bus_pkg::EXT_ADDR_W-1:0];

  ext_bus_phase u_phase (
    .mclk_i   (mclk_i),
    .srst_i   (srst_i),
    .start_i  (start),
    .busy_o   (busy),
    .second_o (second),
    .last_o   (last),
    .flip_o   (phase_flip)
  );

  // shared line value and enable for the half about to run
  logic [15:0] next_ad, next_oe;
  wire        in_cycle   = start || (busy && !last);
  // pins are registered, so the data half is picked one clock before the turn
  wire        data_half  = busy && !last && (second || phase_flip);
  // width and muxing follow the chip-select setting captured with the request
  wire        b16 = cur.cfg.bus16;
  wire        dmx = cur.cfg.demux;
  wire [15:0] wr_oe = cur.write ? 16'hFFFF : 16'h0000;
  wire [15:0] hi_byte = {int_bus_hi_i[15:8], 8'h00};

  always_comb begin
    next_ad = 16'h0000;
    next_oe = 16'h0000;
    if (in_cycle) begin
      if (dmx && b16) begin
        next_ad = cur.wdata;
        next_oe = wr_oe;
      end else if (dmx) begin
        next_ad = {hi_byte[15:8], cur.wdata[7:0]};
        next_oe = {16'hFF00 | (wr_oe & 16'h00FF)};
      end else if (!data_half) begin
        next_ad = pin_addr[15:0];
        next_oe = 16'hFFFF;
      end else if (b16) begin
        next_ad = cur.wdata;
        next_oe = wr_oe;
      end else begin
        next_ad = {pin_addr[15:8], cur.wdata[7:0]};
        next_oe = 16'hFF00 | (wr_oe & 16'h00FF);
      end
    end
  end

  // strap pin sampler; no reset, so the level has settled when reset lifts
  // limitation: a strap change after release is ignored until the next reset
  always_ff @(posedge mclk_i) begin
    strap_sync <= {strap_sync[1:0], exec_ext_i};
    if (strap_sync[1] == strap_sync[2]) strap_q <= strap_sync[2];
  end

  // capture request; launch only external cycles
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cur   <= '0;
      start <= 1'b0;
    end else begin
      start <= go_ext;
      if (accept) cur <= req_i;
    end
  end

  // pin drivers, all registered
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      low_addr_out_o     <= 16'h0000;
      ext_addr_out_o     <= 5'h00;
      shared_addr_data_o <= 16'h0000;
      shared_oe_o        <= 16'h0000;
      address_valid_n_o  <= 1'b1;
    end else begin
      if (start) begin
        low_addr_out_o <= pin_addr[15:0];
        ext_addr_out_o <= pin_addr[20:16];
      end
      shared_addr_data_o <= next_ad;
      shared_oe_o        <= next_oe;
      address_valid_n_o  <= !in_cycle;
    end
  end

  // three-stage sampling of the shared lines
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      {ad_s1, ad_s2, ad_s3, ad_q} <= '0;
    end else begin
      ad_s1 <= ad_in_i;
      ad_s2 <= ad_s1;
      ad_s3 <= ad_s2;
      if (ad_s2 == ad_s3) ad_q <= ad_s3;
    end
  end

  // handshake, read data, reset fetch address
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      req_ready_o   <= 1'b0;
      done_o        <= 1'b0;
      ext_access_o  <= 1'b0;
      rdata_o       <= 16'h0000;
      reset_seen    <= 1'b0;
      reset_fetch_o <= 24'h00_0000;
      drain         <= 3'h0;
    end else begin
      reset_seen  <= 1'b1;
      drain       <= {drain[1:0], last};                     // sampler lags the pins by three clocks
      if (!reset_seen)                                       // strap caught after release
        reset_fetch_o <= strap_q ? ext_bus_pkg::RESET_EXT_FETCH
                                 : ext_bus_pkg::RESET_INT_FETCH;
      // no new request until the sampler has drained the finished cycle
      req_ready_o <= reset_seen && !accept && !start && !busy && (drain == 3'h0);
      done_o      <= int_done || drain[2];
      if (accept) ext_access_o <= is_external(req_i.addr);
      // read data taken once stages two and three both held the data half
      if (drain[2] && !cur.write)
        rdata_o <= b16 ? ad_q : {8'h00, ad_q[7:0]};
    end
  end

  // strobe never falls for an internal access
  strobe_internal_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    int_done |=> ##1 address_valid_n_o) else $error("strobe low on internal access");
  // strobe low for the whole external cycle
  strobe_frame_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    go_ext |=> ##1 (!address_valid_n_o)[*4] ##1 address_valid_n_o) else $error("strobe frame wrong");
  // addresses stable through the cycle
  addr_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !address_valid_n_o && !$past(address_valid_n_o) |-> $stable(low_addr_out_o) && $stable(ext_addr_out_o))
    else $error("address moved mid cycle");
  // extended pins carry the upper address bits
  ext_addr_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    go_ext |=> ##1 ext_addr_out_o == cur.addr[20:16]) else $error("extended address wrong");
  // mux first half carries the address on the shared lines
  mux_addr_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    go_ext && !req_i.cfg.demux |=> ##1 shared_addr_data_o == cur.addr[15:0] && shared_oe_o == 16'hFFFF)
    else $error("mux address phase wrong");
  // 8-bit mux keeps the address high byte out all cycle
  upper_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !address_valid_n_o && !cur.cfg.demux && !cur.cfg.bus16 |-> shared_addr_data_o[15:8] == cur.addr[15:8])
    else $error("upper byte lost address");
  // 16-bit demux write shows data for the whole cycle
  demux_data_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !address_valid_n_o && cur.cfg.demux && cur.cfg.bus16 && cur.write |-> shared_addr_data_o == cur.wdata)
    else $error("demux data wrong");
  // reset fetch low bits are common to both straps
  fetch_addr_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    reset_seen && $past(reset_seen) |-> reset_fetch_o[15:0] == 16'h2080) else $error("fetch address wrong");
  // a low strobe always belongs to an access decoded as external
  strobe_ext_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !address_valid_n_o |-> ext_access_o) else $error("strobe low without external access");
  // 8-bit demux keeps the upper byte driven for the whole cycle
  demux_upper_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    !address_valid_n_o && cur.cfg.demux && !cur.cfg.bus16 |-> shared_oe_o[15:8] == 8'hFF)
    else $error("upper byte released in demux");
  // mux data half: low byte written out or released for the read
  mux_data_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    go_ext && !req_i.cfg.demux |=> ##3 (cur.write ? shared_addr_data_o[7:0] == cur.wdata[7:0]
                                                  : shared_oe_o[7:0] == 8'h00))
    else $error("mux data half wrong");
  // completion waits for the line sampler after the strobe rises
  done_late_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    go_ext |=> ##8 done_o && address_valid_n_o) else $error("external completion timing wrong");
endmodule : ext_bus_pins

// ===== ext_mem_model.sv
// external memory model behind the shared lines, decoding the dedicated address pins
// assumes the strobe frames each cycle and the device releases lines by its enables
`timescale 1ns/100ps
module ext_mem_model (
  input  wire logic        mclk_i,            // core clock
  input  wire logic        address_valid_n_i, // strobe from the device
  input  wire logic [15:0] low_addr_i,        // dedicated low address
  input  wire logic [4:0]  ext_addr_i,        // extended address
  input  wire logic [15:0] lines_i,           // shared lines as driven
  input  wire logic [15:0] lines_oe_i,        // device drive enables
  output logic      [15:0] lines_o            // memory side of released lines
);
  logic [15:0] mem [logic [20:0]];            // written words only
  logic [20:0] addr;                          // decoded pin address
  logic [15:0] noise    = 16'h0f0f;           // released lines toggle, never hold
  logic [15:0] last_out = 16'h0000;           // lines seen in last strobe-low cycle
  logic        last_oe  = 1'b0;               // device drove data at the end
  logic        was_low  = 1'b0;               // strobe low one edge ago
  assign addr = {ext_addr_i, low_addr_i};
  // unwritten words read back a pattern derived from the address
  assign lines_o = address_valid_n_i ? noise :
                   (mem.exists(addr) ? mem[addr] : addr[15:0] ^ 16'h5a3c);
  // a write lands when the strobe rises, using the last data the device drove
  always @(posedge mclk_i) begin
    noise <= ~noise;
    was_low <= !address_valid_n_i;
    if (!address_valid_n_i) begin
      last_out <= lines_i;
      last_oe <= lines_oe_i[0];
    end
    if (was_low && address_valid_n_i && last_oe) mem[addr] = last_out;
  end
endmodule : ext_mem_model

// ===== external_addr_data_bus_pins_tb.sv
// self-checking bench for the external bus pin block, random and corner accesses
// assumes the memory model answers on released shared lines
`timescale 1ns/100ps
module external_addr_data_bus_pins_tb;
  logic mclk_i = 1'b0, srst_i = 1'b1, exec_ext_i = 1'b0, req_valid_i = 1'b0;
  ext_bus_pkg::bus_req_t req_i = '0;
  logic [15:0] int_bus_hi_i = 16'h0000, ad_in_i, mem_lines, rdata_o, low_addr_out_o;
  logic [15:0] shared_addr_data_o, shared_oe_o;
  logic        req_ready_o, ext_access_o, done_o, address_valid_n_o;
  logic [23:0] reset_fetch_o;
  logic [4:0]  ext_addr_out_o;
  logic [31:0] seed = 32'hea28_869d;
  int          fail_count = 0, total_checks = 0;
  logic [15:0] ref_mem [logic [20:0]];         // expected memory contents
  always #12.5 mclk_i = ~mclk_i;
  // device wins where it drives, memory model elsewhere
  assign ad_in_i = (shared_oe_o & shared_addr_data_o) | (~shared_oe_o & mem_lines);
  ext_bus_pins u_dut (.mclk_i, .srst_i, .exec_ext_i, .req_valid_i, .req_i, .int_bus_hi_i, .ad_in_i,
    .req_ready_o, .ext_access_o, .done_o, .rdata_o, .reset_fetch_o, .low_addr_out_o, .ext_addr_out_o,
    .shared_addr_data_o, .shared_oe_o, .address_valid_n_o);
  ext_mem_model u_mem (.mclk_i, .address_valid_n_i(address_valid_n_o), .low_addr_i(low_addr_out_o),
    .ext_addr_i(ext_addr_out_o), .lines_i(shared_addr_data_o), .lines_oe_i(shared_oe_o), .lines_o(mem_lines));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected enables and driven values on the shared lines in strobe cycle k
  function automatic logic [31:0] lines(logic [23:0] a, logic w, logic [15:0] d, logic [1:0] c, int k,
                                        logic [7:0] h);
    logic [15:0] o, e;
    logic ah;
    ah = !c[0] && k < 2;
    o = ah ? a[15:0] : d;
    e = (ah || w) ? 16'hffff : 16'h0000;
    if (!c[1]) begin
      o[15:8] = c[0] ? h : a[15:8];
      e[15:8] = 8'hff;
    end
    return {e, o & e};
  endfunction : lines
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic do_reset(input logic ext);
    @(negedge mclk_i);
    srst_i = 1'b1;
    exec_ext_i = ext;
    repeat (16) @(negedge mclk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask : do_reset
  // one access: request, watch every strobe cycle, then check completion
  task automatic acc(input logic [23:0] a, input logic w, input logic [15:0] d, input logic [1:0] c);
    int n, lows;
    logic ext;
    logic [15:0] v;
    n = 0;
    lows = 0;
    ext = (a <= 24'h1f_ffff);
    int_bus_hi_i = 16'(rnd());
    while (req_ready_o !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    req_i = {a, w, d, c};
    req_valid_i = 1'b1;
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      if (address_valid_n_o === 1'b0) begin
        chk({ext_addr_out_o, low_addr_out_o}, a[20:0]);
        chk({shared_oe_o, shared_addr_data_o & shared_oe_o}, lines(a, w, d, c, lows, int_bus_hi_i[15:8]));
        lows++;
      end
      @(negedge mclk_i);
      n++;
    end
    // internal: done on the taking edge; external: 4 strobe clocks, start and sampler drain
    chk(n, ext ? 8 : 0);
    chk(lows, ext ? 4 : 0);
    chk({address_valid_n_o, ext_access_o, req_ready_o, shared_oe_o}, {1'b1, ext, 1'b0, 16'h0000});
    if (ext && w) ref_mem[a[20:0]] = c[1] ? d : {(c[0] ? int_bus_hi_i[15:8] : a[15:8]), d[7:0]};
    v = ref_mem.exists(a[20:0]) ? ref_mem[a[20:0]] : a[15:0] ^ 16'h5a3c;
    if (ext && !w) chk(rdata_o, c[1] ? v : {8'h00, v[7:0]});
  endtask : acc
  // main sequence: corners per mode, then random traffic, then external strap
  initial begin
    logic [23:0] a;
    logic [31:0] r;
    do_reset(1'b0);
    chk(reset_fetch_o, 24'hff_2080);
    for (int i = 0; i < 8; i++) begin
      a = i[0] ? 24'h1f_ffff : 24'h00_0000;
      acc(a, 1'b1, 16'(rnd()), i[2:1]);
      acc(a, 1'b0, 16'h0000, i[2:1]);
    end
    acc(24'hff_ffff, 1'b0, 16'h0000, 2'b10);
    acc(24'h20_0000, 1'b1, 16'h1234, 2'b00);
    repeat (60) begin
      r = rnd();
      a = r[31] ? {3'b000, r[20:0]} : (r[23:0] | 24'h20_0000);
      acc(a, r[30], 16'(rnd()), r[29:28]);
      if (r[30]) acc(a, 1'b0, 16'h0000, r[29:28]);
    end
    do_reset(1'b1);
    chk(reset_fetch_o, 24'h1f_2080);
    acc(24'h1f_2080, 1'b0, 16'h0000, 2'b11);
    end_sim();
  end
  // watchdog, far beyond the expected run length
  initial begin
    #250us;
    fail_count++;
    end_sim();
  end
endmodule : external_addr_data_bus_pins_tb
